// >>> hdl/pgr_top.sv
// Electronic gear, quadrature pulse reproduction, torque clamp and deviation alarms
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pgr_top #(
    parameter logic [31:0] ENC_RES = 32'h00100000,
    parameter int unsigned BACKLOG_SHIFT = 10
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic CTRL_POWER_UP,
    input wire logic FULL_CLOSED,
    input wire logic CMD_STEP,
    input wire logic CMD_DIR,
    input wire logic ENC_STEP,
    input wire logic ENC_DIR,
    input wire logic ENC_Z,
    input wire logic SCL_STEP,
    input wire logic SCL_DIR,
    input wire logic SCL_Z,
    output logic POS_STEP,
    output logic POS_DIR,
    output logic OUT_PHASE_A,
    output logic OUT_PHASE_B,
    output logic OUT_PHASE_Z,
    input wire logic signed [pgr_pkg::TRQ_W-1:0] TORQUE_CMD,
    output logic signed [pgr_pkg::TRQ_W-1:0] TORQUE_OUT,
    output logic MULT_ERROR_ALARM,
    output logic HYBRID_OVER_DEVIATION_ALARM,
    output logic DEVIATION_EXCESS_ALARM
);
    // Reset release through two flops
    logic rst_s1_reg, rst_n;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // Write decode
    wire wr_cppr = WR && ADDR == pgr_pkg::ADDR_CMD_PPR;
    wire wr_num = WR && ADDR == pgr_pkg::ADDR_GEAR_NUM;
    wire wr_den = WR && ADDR == pgr_pkg::ADDR_GEAR_DEN;
    wire wr_oppr = WR && ADDR == pgr_pkg::ADDR_OUT_PPR;
    wire wr_odiv = WR && ADDR == pgr_pkg::ADDR_OUT_DIV;
    wire wr_sel = WR && ADDR == pgr_pkg::ADDR_OUT_SEL;
    wire wr_tlim = WR && ADDR == pgr_pkg::ADDR_TRQ_LIM;
    wire wr_dlim = WR && ADDR == pgr_pkg::ADDR_DEV_LIM;
    wire wr_unit = WR && ADDR == pgr_pkg::ADDR_POS_UNIT;
    wire wr_alarm = WR && ADDR == pgr_pkg::ADDR_ALARM;

    // Stored settings; command PPR and output PPR, divider and select have a pending copy and an active copy
    logic [pgr_pkg::CPPR_W-1:0] cppr_reg, cppr_act;
    logic [pgr_pkg::GEAR_W-1:0] gear_num_reg, gear_den_reg;
    logic [pgr_pkg::OPPR_W-1:0] oppr_reg, oppr_act, odiv_reg, odiv_act;
    logic [1:0] sel_reg, sel_act;
    logic [pgr_pkg::TLIM_W-1:0] tlim_reg;
    logic [pgr_pkg::DLIM_W-1:0] dlim_reg;
    logic unit_reg;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cppr_reg <= pgr_pkg::RST_CMD_PPR;
            gear_num_reg <= pgr_pkg::RST_GEAR_NUM;
            gear_den_reg <= pgr_pkg::RST_GEAR_DEN;
            oppr_reg <= pgr_pkg::RST_OUT_PPR;
            odiv_reg <= pgr_pkg::RST_OUT_DIV;
            sel_reg <= pgr_pkg::RST_OUT_SEL;
            tlim_reg <= pgr_pkg::RST_TRQ_LIM;
            dlim_reg <= pgr_pkg::RST_DEV_LIM;
            unit_reg <= pgr_pkg::RST_POS_UNIT;
        end else begin
            if (wr_cppr) cppr_reg <= WDATA[pgr_pkg::CPPR_W-1:0];
            if (wr_num) gear_num_reg <= WDATA[pgr_pkg::GEAR_W-1:0];
            if (wr_den) gear_den_reg <= WDATA[pgr_pkg::GEAR_W-1:0];
            if (wr_oppr) oppr_reg <= WDATA[pgr_pkg::OPPR_W-1:0];
            if (wr_odiv) odiv_reg <= WDATA[pgr_pkg::OPPR_W-1:0];
            if (wr_sel) sel_reg <= WDATA[1:0];
            if (wr_tlim) tlim_reg <= WDATA[pgr_pkg::TLIM_W-1:0];
            if (wr_dlim) dlim_reg <= WDATA[pgr_pkg::DLIM_W-1:0];
            if (wr_unit) unit_reg <= WDATA[0];
        end
    end

    // Active copies only move at control power-up, so live edits cannot upset a running axis
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cppr_act <= pgr_pkg::RST_CMD_PPR;
            oppr_act <= pgr_pkg::RST_OUT_PPR;
            odiv_act <= pgr_pkg::RST_OUT_DIV;
            sel_act <= pgr_pkg::RST_OUT_SEL;
        end else if (CTRL_POWER_UP) begin
            cppr_act <= cppr_reg;
            oppr_act <= oppr_reg;
            odiv_act <= odiv_reg;
            sel_act <= sel_reg;
        end
    end

    // Gear ratio selection
    wire num_zero = gear_num_reg == '0;
    wire [31:0] num_w = {1'b0, gear_num_reg};
    wire [31:0] den_w = {1'b0, gear_den_reg};
    wire [31:0] g_num = FULL_CLOSED ? (num_zero ? 32'h00000001 : num_w)
                      : ((cppr_act != '0 || num_zero) ? ENC_RES : num_w);
    wire [31:0] g_den = FULL_CLOSED ? (num_zero ? 32'h00000001 : den_w)
                      : (cppr_act != '0 ? {11'h000, cppr_act} : den_w);

    // Gear accumulator keeps the remainder; at most one scaled pulse leaves per cycle
    logic signed [47:0] gacc_reg;
    wire signed [47:0] g_num_s = {16'h0000, g_num};
    wire signed [47:0] g_den_s = {16'h0000, g_den};
    wire signed [47:0] g_lim = g_den_s <<< BACKLOG_SHIFT;
    wire signed [47:0] gacc_add = CMD_STEP ? (CMD_DIR ? gacc_reg - g_num_s : gacc_reg + g_num_s) : gacc_reg;
    wire g_emit_pos = g_den != '0 && gacc_add >= g_den_s;
    wire g_emit_neg = g_den != '0 && gacc_add <= -g_den_s;
    wire signed [47:0] gacc_next = g_emit_pos ? gacc_add - g_den_s : (g_emit_neg ? gacc_add + g_den_s : gacc_add);
    // Backlog beyond the limit means the ratio outruns the one-pulse-per-cycle output
    wire mult_evt = (CMD_STEP && g_den == '0) || gacc_next > g_lim || gacc_next < -g_lim;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            gacc_reg <= '0;
            POS_STEP <= 1'b0;
            POS_DIR <= 1'b0;
        end else begin
            gacc_reg <= mult_evt ? '0 : gacc_next;
            POS_STEP <= g_emit_pos || g_emit_neg;
            if (g_emit_pos || g_emit_neg) POS_DIR <= g_emit_neg;
        end
    end

    // Gear change while the loop is closed on the scale
    wire hyb_evt = FULL_CLOSED && ((wr_num && WDATA[pgr_pkg::GEAR_W-1:0] != gear_num_reg)
                || (wr_den && WDATA[pgr_pkg::GEAR_W-1:0] != gear_den_reg));

    // Output source: scale codes fall back to encoder outside full-closed
    wire use_scale = sel_act[1] && FULL_CLOSED;
    wire src_step = use_scale ? SCL_STEP : ENC_STEP;
    wire src_dir = use_scale ? SCL_DIR : ENC_DIR;
    wire src_z = use_scale ? SCL_Z : ENC_Z;
    wire b_rev = sel_act[0];

    // Output division ratio, never above one edge per feedback edge
    wire [31:0] oppr_x4 = {11'h000, oppr_act, 2'b00};
    wire [31:0] oppr_w = {13'h0000, oppr_act};
    wire [31:0] odiv_w = {13'h0000, odiv_act};
    wire [31:0] enc_num = oppr_x4 > ENC_RES ? ENC_RES : oppr_x4;
    wire [31:0] frac_num = oppr_w > odiv_w ? odiv_w : oppr_w;
    wire [31:0] o_num = odiv_act != '0 ? frac_num : (use_scale ? 32'h00000001 : enc_num);
    wire [31:0] o_den = odiv_act != '0 ? odiv_w : (use_scale ? 32'h00000001 : ENC_RES);
    wire nonint = odiv_act != '0;

    // Output accumulator with carried remainder
    logic signed [33:0] oacc_reg;
    wire signed [33:0] o_num_s = {2'b00, o_num};
    wire signed [33:0] o_den_s = {2'b00, o_den};
    wire signed [33:0] oacc_add = src_step ? (src_dir ? oacc_reg - o_num_s : oacc_reg + o_num_s) : oacc_reg;
    wire o_pos = oacc_add >= o_den_s;
    wire o_neg = oacc_add <= -o_den_s;
    wire signed [33:0] oacc_next = o_pos ? oacc_add - o_den_s : (o_neg ? oacc_add + o_den_s : oacc_add);

    // Quadrature phase: one step per reproduced edge, A and B share the count
    logic [1:0] quad_reg, z_prev_reg;
    wire [1:0] quad_next = o_pos ? quad_reg + 2'h1 : (o_neg ? quad_reg - 2'h1 : quad_reg);
    // Integer ratio gates Z with A; otherwise only its first cycle passes
    wire z_next = nonint ? (src_z && !z_prev_reg[0]) : (src_z && quad_next[1]);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            oacc_reg <= '0;
            quad_reg <= 2'h0;
            z_prev_reg <= 2'h0;
            OUT_PHASE_A <= 1'b0;
            OUT_PHASE_B <= 1'b0;
            OUT_PHASE_Z <= 1'b0;
        end else begin
            oacc_reg <= oacc_next;
            quad_reg <= quad_next;
            z_prev_reg <= {1'b0, src_z};
            OUT_PHASE_A <= quad_next[1];
            OUT_PHASE_B <= quad_next[1] ^ quad_next[0] ^ b_rev;
            OUT_PHASE_Z <= z_next;
        end
    end

    // Torque clamp to symmetric limit
    wire signed [pgr_pkg::TRQ_W-1:0] tlim_s = {3'b000, tlim_reg};
    wire signed [pgr_pkg::TRQ_W-1:0] trq_next = TORQUE_CMD > tlim_s ? tlim_s
                                              : (TORQUE_CMD < -tlim_s ? -tlim_s : TORQUE_CMD);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) TORQUE_OUT <= '0;
        else TORQUE_OUT <= trq_next;
    end

    // Deviation: scaled command minus feedback (encoder, or scale in full-closed)
    logic [31:0] dev_reg;
    wire fb_step = FULL_CLOSED ? SCL_STEP : ENC_STEP;
    wire fb_dir = FULL_CLOSED ? SCL_DIR : ENC_DIR;
    wire [1:0] dev_up = {1'b0, g_emit_pos} + {1'b0, fb_step && fb_dir};
    wire [1:0] dev_dn = {1'b0, g_emit_neg} + {1'b0, fb_step && !fb_dir};
    wire [31:0] dev_next = dev_reg + {30'h0, dev_up} - {30'h0, dev_dn};
    wire [31:0] dev_abs = dev_reg[31] ? -dev_reg : dev_reg;
    wire [31:0] dlim_w = {4'h0, dlim_reg};
    // Command units: compare dev*den against limit*num, avoiding a divider
    wire [63:0] dev_cmd = {32'h0, dev_abs} * {32'h0, g_den};
    wire [63:0] lim_cmd = {32'h0, dlim_w} * {32'h0, g_num};
    wire dev_over = unit_reg ? dev_abs > dlim_w : dev_cmd > lim_cmd;
    wire dev_evt = dlim_reg != '0 && dev_over;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) dev_reg <= '0;
        else dev_reg <= dev_next;
    end

    // Sticky alarms; write one to clear, a new event in the same cycle wins
    logic [2:0] alarm_reg;
    wire [2:0] alarm_evt = {dev_evt, hyb_evt, mult_evt};
    wire [2:0] alarm_clr = wr_alarm ? WDATA[2:0] : 3'h0;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) alarm_reg <= 3'h0;
        else alarm_reg <= (alarm_reg & ~alarm_clr) | alarm_evt;
    end
    assign MULT_ERROR_ALARM = alarm_reg[pgr_pkg::ALM_MULT];
    assign HYBRID_OVER_DEVIATION_ALARM = alarm_reg[pgr_pkg::ALM_HYBRID];
    assign DEVIATION_EXCESS_ALARM = alarm_reg[pgr_pkg::ALM_DEV];

    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        ADDR == pgr_pkg::ADDR_CMD_PPR ? {11'h000, cppr_reg} :
        ADDR == pgr_pkg::ADDR_GEAR_NUM ? num_w :
        ADDR == pgr_pkg::ADDR_GEAR_DEN ? den_w :
        ADDR == pgr_pkg::ADDR_OUT_PPR ? {13'h0000, oppr_reg} :
        ADDR == pgr_pkg::ADDR_OUT_DIV ? {13'h0000, odiv_reg} :
        ADDR == pgr_pkg::ADDR_OUT_SEL ? {30'h0, sel_reg} :
        ADDR == pgr_pkg::ADDR_TRQ_LIM ? {23'h000000, tlim_reg} :
        ADDR == pgr_pkg::ADDR_DEV_LIM ? dlim_w :
        ADDR == pgr_pkg::ADDR_POS_UNIT ? {31'h0, unit_reg} :
        ADDR == pgr_pkg::ADDR_ALARM ? {29'h0, alarm_reg} :
        ADDR == pgr_pkg::ADDR_DEVIATION ? dev_reg : 32'h00000000;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) RDATA <= '0;
        else RDATA <= RD ? rd_mux : 32'h00000000;
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);
    sequence s_emit_pos;
        g_emit_pos && !g_emit_neg;
    endsequence
    sequence s_pos_out;
        POS_STEP && !POS_DIR;
    endsequence
    property p_ppr_ratio;
        !FULL_CLOSED && cppr_act != '0 |-> g_num == ENC_RES && g_den == {11'h000, cppr_act};
    endproperty
    a_ppr_ratio: assert property (p_ppr_ratio) else $error("per-rev ratio wrong");
    property p_gear_ratio;
        !FULL_CLOSED && cppr_act == '0 && !num_zero |-> g_num == num_w && g_den == den_w;
    endproperty
    a_gear_ratio: assert property (p_gear_ratio) else $error("gear ratio wrong");
    property p_fc_unity;
        FULL_CLOSED && num_zero |-> g_num == 32'h00000001 && g_den == 32'h00000001;
    endproperty
    a_fc_unity: assert property (p_fc_unity) else $error("full-closed unity ratio wrong");
    property p_step_out;
        s_emit_pos |=> s_pos_out;
    endproperty
    a_step_out: assert property (p_step_out) else $error("scaled pulse not issued");
    property p_mult;
        mult_evt |=> MULT_ERROR_ALARM ##1 (MULT_ERROR_ALARM || $past(wr_alarm));
    endproperty
    a_mult: assert property (p_mult) else $error("multiplication alarm missing");
    property p_hybrid;
        FULL_CLOSED && wr_num && WDATA[pgr_pkg::GEAR_W-1:0] != gear_num_reg |=> HYBRID_OVER_DEVIATION_ALARM;
    endproperty
    a_hybrid: assert property (p_hybrid) else $error("hybrid alarm missing");
    property p_dev_off;
        dlim_reg == '0 && !DEVIATION_EXCESS_ALARM |=> !DEVIATION_EXCESS_ALARM;
    endproperty
    a_dev_off: assert property (p_dev_off) else $error("disabled check raised alarm");
    property p_dev_on;
        dev_evt |=> DEVIATION_EXCESS_ALARM;
    endproperty
    a_dev_on: assert property (p_dev_on) else $error("deviation alarm missing");
    property p_trq;
        1'b1 |=> TORQUE_OUT <= $past(tlim_s) && TORQUE_OUT >= -$past(tlim_s);
    endproperty
    a_trq: assert property (p_trq) else $error("torque not clamped");
    property p_latch;
        !CTRL_POWER_UP |=> oppr_act == $past(oppr_act) && sel_act == $past(sel_act);
    endproperty
    a_latch: assert property (p_latch) else $error("setting applied before power-up");
    property p_cap;
        o_num <= o_den;
    endproperty
    a_cap: assert property (p_cap) else $error("output ratio above one");
    property p_src;
        !FULL_CLOSED |-> !use_scale;
    endproperty
    a_src: assert property (p_src) else $error("scale source outside full-closed");
    property p_den_ratio;
        !FULL_CLOSED && cppr_act == '0 && num_zero |-> g_num == ENC_RES && g_den == den_w;
    endproperty
    a_den_ratio: assert property (p_den_ratio) else $error("resolution over denominator wrong");
    property p_hyb_den;
        FULL_CLOSED && wr_den && WDATA[pgr_pkg::GEAR_W-1:0] != gear_den_reg |=> HYBRID_OVER_DEVIATION_ALARM;
    endproperty
    a_hyb_den: assert property (p_hyb_den) else $error("hybrid alarm missing on denominator change");
    property p_z_src;
        use_scale && !SCL_Z |=> !OUT_PHASE_Z;
    endproperty
    a_z_src: assert property (p_z_src) else $error("Z taken from wrong source");
endmodule // pgr_top
`default_nettype wire

// >>> hdl/pgr_pkg.sv
// Constants shared by the pulse gear and reproduction logic
package pgr_pkg;
    // Field widths
    localparam int CPPR_W = 21;
    localparam int GEAR_W = 31;
    localparam int OPPR_W = 19;
    localparam int TLIM_W = 9;
    localparam int DLIM_W = 28;
    localparam int TRQ_W = 12;
    // Register byte offsets
    localparam logic [7:0] ADDR_CMD_PPR = 8'h00;
    localparam logic [7:0] ADDR_GEAR_NUM = 8'h04;
    localparam logic [7:0] ADDR_GEAR_DEN = 8'h08;
    localparam logic [7:0] ADDR_OUT_PPR = 8'h0c;
    localparam logic [7:0] ADDR_OUT_DIV = 8'h10;
    localparam logic [7:0] ADDR_OUT_SEL = 8'h14;
    localparam logic [7:0] ADDR_TRQ_LIM = 8'h18;
    localparam logic [7:0] ADDR_DEV_LIM = 8'h1c;
    localparam logic [7:0] ADDR_POS_UNIT = 8'h20;
    localparam logic [7:0] ADDR_ALARM = 8'h24;
    localparam logic [7:0] ADDR_DEVIATION = 8'h28;
    // Values after reset
    localparam logic [CPPR_W-1:0] RST_CMD_PPR = 21'h002710;
    localparam logic [GEAR_W-1:0] RST_GEAR_NUM = 31'h00000000;
    localparam logic [GEAR_W-1:0] RST_GEAR_DEN = 31'h00002710;
    localparam logic [OPPR_W-1:0] RST_OUT_PPR = 19'h009c4;
    localparam logic [OPPR_W-1:0] RST_OUT_DIV = 19'h00000;
    localparam logic [1:0] RST_OUT_SEL = 2'h0;
    localparam logic [TLIM_W-1:0] RST_TRQ_LIM = 9'h1f4;
    localparam logic [DLIM_W-1:0] RST_DEV_LIM = 28'h00186a0;
    localparam logic RST_POS_UNIT = 1'b0;
    // Alarm bit positions
    localparam int ALM_MULT = 0;
    localparam int ALM_HYBRID = 1;
    localparam int ALM_DEV = 2;
    // Output logic select codes
    typedef enum logic [1:0] {
        PGR_SEL_ENC_NORM = 2'b00,
        PGR_SEL_ENC_REV = 2'b01,
        PGR_SEL_SCL_NORM = 2'b10,
        PGR_SEL_SCL_REV = 2'b11
    } pgr_sel_t;
endpackage

// >>> tb/pgr_far.sv
// Behavioural host controller and feedback source driving step and direction pulses
`timescale 1ns/1ns
`default_nettype none
module pgr_far (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic neg,
    input wire logic [7:0] count,
    input wire logic slow,
    output logic cmd_step,
    output logic cmd_dir,
    output logic enc_step,
    output logic enc_dir,
    output logic scl_step,
    output logic scl_dir,
    output logic busy
);
    logic [7:0] left_reg = 8'h00;
    logic [1:0] src_reg = 2'h0;
    logic neg_reg = 1'b0;
    logic gap_reg = 1'b0;
    logic idle_reg = 1'b0;
    logic stepping;
    logic dir_out;
    // Burst engine; a slow burst leaves one empty cycle after every step
    always @(posedge clk) begin
        idle_reg <= ~idle_reg;
        if (go) begin
            left_reg <= count;
            src_reg <= src;
            neg_reg <= neg;
            gap_reg <= 1'b0;
        end else if (left_reg != 8'h00 && !gap_reg) begin
            left_reg <= left_reg - 8'h01;
            gap_reg <= slow;
        end else begin
            gap_reg <= 1'b0;
        end
    end
    // Direction toggles while idle so that no stale level can be mistaken for a valid one
    assign stepping = (left_reg != 8'h00) && !gap_reg;
    assign dir_out = stepping ? neg_reg : idle_reg;
    assign cmd_step = stepping && (src_reg == 2'h0);
    assign enc_step = stepping && (src_reg == 2'h1);
    assign scl_step = stepping && (src_reg == 2'h2);
    assign cmd_dir = dir_out;
    assign enc_dir = dir_out;
    assign scl_dir = dir_out;
    assign busy = left_reg != 8'h00;
endmodule // pgr_far
`default_nettype wire

// >>> tb/pgr_top_tb_top.sv
// Self-checking bench for the pulse gear and reproduction block
`timescale 1ns/1ns
`default_nettype none
module pgr_top_tb_top;
    logic CLK, NRST, WR, RD, CTRL_POWER_UP, FULL_CLOSED, CMD_STEP, CMD_DIR, ENC_STEP, ENC_DIR, ENC_Z, SCL_Z;
    logic SCL_STEP, SCL_DIR, POS_STEP, POS_DIR, OUT_PHASE_A, OUT_PHASE_B, OUT_PHASE_Z, far_go, far_neg;
    logic MULT_ERROR_ALARM, HYBRID_OVER_DEVIATION_ALARM, DEVIATION_EXCESS_ALARM, far_slow, far_busy;
    logic [7:0] ADDR, far_cnt;
    logic [1:0] far_src;
    logic [31:0] WDATA, RDATA, v;
    logic signed [pgr_pkg::TRQ_W-1:0] TORQUE_CMD, TORQUE_OUT;
    int fail_count = 0, n_compared = 0, pos_cnt = 0, p = 0;
    logic [31:0] dflt [0:11] = '{32'h00002710, 32'h0, 32'h00002710, 32'h000009c4, 32'h0, 32'h0, 32'h000001f4,
        32'h000186a0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [35:0] tq [0:3] = '{{12'h064, 12'h12c, 12'h064}, {12'h064, 12'hed4, 12'hf9c},
        {12'h064, 12'h032, 12'h032}, {12'h000, 12'h032, 12'h000}};
    // Small resolution and backlog keep every count short
    pgr_top #(.ENC_RES(32'h00000400), .BACKLOG_SHIFT(2)) uut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CTRL_POWER_UP(CTRL_POWER_UP),
        .FULL_CLOSED(FULL_CLOSED), .CMD_STEP(CMD_STEP), .CMD_DIR(CMD_DIR), .ENC_STEP(ENC_STEP),
        .ENC_DIR(ENC_DIR), .ENC_Z(ENC_Z), .SCL_STEP(SCL_STEP), .SCL_DIR(SCL_DIR), .SCL_Z(SCL_Z),
        .POS_STEP(POS_STEP), .POS_DIR(POS_DIR), .OUT_PHASE_A(OUT_PHASE_A), .OUT_PHASE_B(OUT_PHASE_B),
        .OUT_PHASE_Z(OUT_PHASE_Z), .TORQUE_CMD(TORQUE_CMD), .TORQUE_OUT(TORQUE_OUT),
        .MULT_ERROR_ALARM(MULT_ERROR_ALARM), .HYBRID_OVER_DEVIATION_ALARM(HYBRID_OVER_DEVIATION_ALARM),
        .DEVIATION_EXCESS_ALARM(DEVIATION_EXCESS_ALARM));
    pgr_far far (.clk(CLK), .go(far_go), .src(far_src), .neg(far_neg), .count(far_cnt), .slow(far_slow),
        .cmd_step(CMD_STEP), .cmd_dir(CMD_DIR), .enc_step(ENC_STEP), .enc_dir(ENC_DIR),
        .scl_step(SCL_STEP), .scl_dir(SCL_DIR), .busy(far_busy));
    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Signed tally of scaled position pulses
    always @(posedge CLK) begin
        if (POS_STEP === 1'b1) begin
            pos_cnt <= (POS_DIR === 1'b1) ? pos_cnt - 1 : pos_cnt + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rst;
        NRST <= 1'b0;
        repeat (10) @(posedge CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK);
    endtask
    // Register access; the extra cycle keeps each strobe from being reassigned in one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        v = RDATA;
    endtask
    task automatic pwr;
        CTRL_POWER_UP <= 1'b1;
        @(posedge CLK);
        CTRL_POWER_UP <= 1'b0;
        @(posedge CLK);
    endtask
    // Source 0 command, 1 encoder, 2 scale; waits for the burst, then lets the pipeline drain
    task automatic burst(input logic [1:0] s, input logic ng, input logic [7:0] c, input logic sl);
        int i;
        far_src <= s;
        far_neg <= ng;
        far_cnt <= c;
        far_slow <= sl;
        far_go <= 1'b1;
        @(posedge CLK);
        far_go <= 1'b0;
        for (i = 0; i < 2000 && (far_busy || i < 2); i++) @(posedge CLK);
        if (far_busy) begin
            fail_count++;
            close_out;
        end
        repeat (16) @(posedge CLK);
    endtask
    task automatic gear(input logic ng, input logic [7:0] c, input int exp);
        int n;
        n = pos_cnt;
        burst(2'h0, ng, c, 1'b1);
        chk("pos_steps", 32'(pos_cnt - n), 32'(exp));
    endtask
    task automatic quad(input logic s0);
        // One edge first, so an output launched at the caller's last edge has landed
        @(posedge CLK);
        chk("phase_a", {31'h0, OUT_PHASE_A}, {31'h0, p[1]});
        chk("phase_b", {31'h0, OUT_PHASE_B}, {31'h0, p[1] ^ p[0] ^ s0});
    endtask
    task automatic zcnt(input logic es, input logic ss, input int exp);
        int i, k;
        k = 0;
        ENC_Z <= es;
        SCL_Z <= ss;
        for (i = 0; i < 10; i++) begin
            @(posedge CLK);
            if (i == 3) begin
                ENC_Z <= 1'b0;
                SCL_Z <= 1'b0;
            end
            k += (OUT_PHASE_Z === 1'b1) ? 1 : 0;
        end
        chk("z_cycles", 32'(k), 32'(exp));
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge CLK);
        fail_count++;
        close_out;
    end
    // Main sequence; ratios stay within one thousandth to one thousand
    initial begin
        {NRST, WR, RD, CTRL_POWER_UP, FULL_CLOSED, ENC_Z, SCL_Z, far_go, far_neg, far_slow} = 10'h0;
        {ADDR, far_cnt, far_src, WDATA, TORQUE_CMD} = '0;
        rst;
        foreach (dflt[i]) begin
            rd(8'(4 * i));
            chk("reg_default", v, dflt[i]);
        end
        @(posedge CLK);
        chk("rdata_idle", RDATA, 32'h0);
        burst(2'h1, 1'b0, 8'd3, 1'b0);
        p = 3;
        quad(1'b0);
        wr(pgr_pkg::ADDR_OUT_SEL, 32'h1);
        quad(1'b0);
        pwr;
        quad(1'b1);
        wr(pgr_pkg::ADDR_OUT_PPR, 32'h80);
        pwr;
        burst(2'h1, 1'b0, 8'd4, 1'b0);
        p = 5;
        quad(1'b1);
        burst(2'h1, 1'b1, 8'd2, 1'b0);
        p = 4;
        quad(1'b1);
        wr(pgr_pkg::ADDR_CMD_PPR, 32'h200);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h3);
        pwr;
        gear(1'b0, 8'd10, 20);
        wr(pgr_pkg::ADDR_CMD_PPR, 32'h0);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h0);
        wr(pgr_pkg::ADDR_GEAR_DEN, 32'h200);
        pwr;
        gear(1'b0, 8'd5, 10);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h2);
        wr(pgr_pkg::ADDR_GEAR_DEN, 32'h1);
        gear(1'b1, 8'd10, -20);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h64);
        burst(2'h0, 1'b0, 8'd10, 1'b0);
        chk("mult_alarm", {31'h0, MULT_ERROR_ALARM}, 32'h1);
        wr(pgr_pkg::ADDR_ALARM, 32'h1);
        rd(pgr_pkg::ADDR_ALARM);
        chk("mult_clear", {31'h0, v[0]}, 32'h0);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h0);
        wr(pgr_pkg::ADDR_GEAR_DEN, 32'h7);
        wr(pgr_pkg::ADDR_CMD_PPR, 32'h200);
        pwr;
        FULL_CLOSED <= 1'b1;
        gear(1'b0, 8'd10, 10);
        rd(pgr_pkg::ADDR_ALARM);
        chk("hybrid_quiet", {31'h0, v[1]}, 32'h0);
        wr(pgr_pkg::ADDR_GEAR_NUM, 32'h3);
        wr(pgr_pkg::ADDR_GEAR_DEN, 32'h2);
        rd(pgr_pkg::ADDR_ALARM);
        chk("hybrid_alarm", {30'h0, HYBRID_OVER_DEVIATION_ALARM, v[1]}, 32'h3);
        wr(pgr_pkg::ADDR_ALARM, 32'h2);
        gear(1'b0, 8'd5, 7);
        gear(1'b0, 8'd5, 8);
        // Scale codes only while full-closed is active
        wr(pgr_pkg::ADDR_OUT_SEL, 32'h2);
        pwr;
        burst(2'h2, 1'b0, 8'd2, 1'b0);
        burst(2'h1, 1'b0, 8'd3, 1'b0);
        p = 6;
        quad(1'b0);
        zcnt(1'b0, 1'b1, 4);
        zcnt(1'b1, 1'b0, 0);
        wr(pgr_pkg::ADDR_OUT_PPR, 32'h2);
        wr(pgr_pkg::ADDR_OUT_DIV, 32'h3);
        wr(pgr_pkg::ADDR_OUT_SEL, 32'h3);
        pwr;
        burst(2'h2, 1'b0, 8'd6, 1'b0);
        p = 10;
        quad(1'b1);
        zcnt(1'b0, 1'b1, 1);
        FULL_CLOSED <= 1'b0;
        rst;
        wr(pgr_pkg::ADDR_CMD_PPR, 32'h400);
        pwr;
        wr(pgr_pkg::ADDR_POS_UNIT, 32'h1);
        wr(pgr_pkg::ADDR_DEV_LIM, 32'h5);
        burst(2'h0, 1'b0, 8'd5, 1'b1);
        rd(pgr_pkg::ADDR_DEVIATION);
        chk("deviation", v, 32'h5);
        chk("dev_quiet", {31'h0, DEVIATION_EXCESS_ALARM}, 32'h0);
        burst(2'h0, 1'b0, 8'd1, 1'b1);
        chk("dev_alarm", {31'h0, DEVIATION_EXCESS_ALARM}, 32'h1);
        burst(2'h1, 1'b0, 8'd6, 1'b1);
        rd(pgr_pkg::ADDR_DEVIATION);
        chk("deviation", v, 32'h0);
        wr(pgr_pkg::ADDR_DEV_LIM, 32'h0);
        wr(pgr_pkg::ADDR_ALARM, 32'h4);
        burst(2'h0, 1'b0, 8'd20, 1'b1);
        chk("dev_disabled", {31'h0, DEVIATION_EXCESS_ALARM}, 32'h0);
        foreach (tq[i]) begin
            wr(pgr_pkg::ADDR_TRQ_LIM, {20'h0, tq[i][35:24]});
            TORQUE_CMD <= tq[i][23:12];
            repeat (2) @(posedge CLK);
            chk("torque_out", {20'h0, TORQUE_OUT}, {20'h0, tq[i][11:0]});
        end
        close_out;
    end
endmodule // pgr_top_tb_top
`default_nettype wire
